// *** design/ivm_mapper.v ***
`include "ivm_defines.vh"

module ivm_mapper #(
  parameter LEVEL_W = 5,
  parameter NUM_LVL = 48
) (
  // clock and reset
  input  wire                       mclk,
  input  wire                       sys_rst,
  // table base and level registers
  input  wire [31:0]                vectorTableBase,
  input  wire [NUM_LVL*LEVEL_W-1:0] sourceLevelRegister,
  // mapping request
  input  wire                       reqValid,
  input  wire [7:0]                 reqVector,
  // source qualifiers for dma
  input  wire                       srcI2cStatus,
  input  wire                       srcClockCalib,
  input  wire                       srcRamEcc,
  input  wire                       srcUpdownCounter2,
  input  wire                       srcGraphics,
  // mapping result
  output reg                        mapValid,
  output reg  [7:0]                 mapVector,
  output reg  [31:0]                vectorAddress,
  output reg  [LEVEL_W-1:0]         vectorLevel,
  output reg                        levelPresent,
  output reg                        levelFixed,
  output reg                        softInterrupt,
  output reg                        faultException,
  // dma request
  output reg                        dmaRequest,
  output reg                        dmaIndexValid,
  output reg  [5:0]                 dmaResourceIndex
);

  // offset of a vector inside the table
  // runs from 0x3fc down to 0 and never wraps; the 32-bit sum with a base near the top of memory wraps
  function [31:0] vecOffset;
    input [7:0] v;
    begin
      vecOffset = `IVM_TOP_OFFSET - {22'h0, v, 2'h0};
    end
  endfunction

  // vector lies in the range served by level registers
  function isPeri;
    input [7:0] v;
    begin
      if (v < `IVM_VEC_PERI_FIRST)
        isPeri = 1'h0;
      else if (v > `IVM_VEC_PERI_LAST)
        isPeri = 1'h0;
      else
        isPeri = 1'h1;
    end
  endfunction

  // level register index, also the dma resource index
  function [5:0] levelIndex;
    input [7:0] v;
    reg   [7:0] diff;
    begin
      diff       = v - `IVM_VEC_PERI_FIRST;
      levelIndex = diff[5:0];
    end
  endfunction

  // resource index present for this vector
  function hasResource;
    input [7:0] v;
    begin
      // exceptions below 16, software or reserved above 63
      if (!isPeri(v))
        hasResource = 1'h0;
      // can controllers and real time clock
      else if ((v >= `IVM_VEC_NORES_A0) && (v <= `IVM_VEC_NORES_A1))
        hasResource = 1'h0;
      // free-run timers
      else if ((v == `IVM_VEC_NORES_B0) || (v == `IVM_VEC_NORES_B1))
        hasResource = 1'h0;
      // dma completion and delay interrupt
      else if (v >= `IVM_VEC_NORES_C0)
        hasResource = 1'h0;
      else
        hasResource = 1'h1;
    end
  endfunction

  // protection, access error and undefined opcode exceptions
  function isFault;
    input [7:0] v;
    begin
      if (v == `IVM_VEC_IPROT)
        isFault = 1'h1;
      else if (v == `IVM_VEC_DPROT)
        isFault = 1'h1;
      else if (v == `IVM_VEC_DERR)
        isFault = 1'h1;
      else if (v == `IVM_VEC_UNDEF)
        isFault = 1'h1;
      else
        isFault = 1'h0;
    end
  endfunction

  // any source that must never turn into a dma request
  // the i2c qualifier is raised only for status caused by reception
  function dmaBlocked;
    input i2cStatus;
    input clockCalib;
    input ramEcc;
    input updown2;
    input graphics;
    begin
      dmaBlocked = 1'h0;
      if (i2cStatus)
        dmaBlocked = 1'h1;
      if (clockCalib)
        dmaBlocked = 1'h1;
      if (ramEcc)
        dmaBlocked = 1'h1;
      if (updown2)
        dmaBlocked = 1'h1;
      if (graphics)
        dmaBlocked = 1'h1;
    end
  endfunction

  // request decode
  wire               isPeripheral = isPeri(reqVector);
  wire               isNmi        = (reqVector == `IVM_VEC_NMI);
  wire               isSoft       = (reqVector >= `IVM_VEC_SOFT_FIRST);
  wire [5:0]         levelSel     = levelIndex(reqVector);
  wire               withIndex    = hasResource(reqVector);
  wire               blocked      = dmaBlocked(srcI2cStatus, srcClockCalib, srcRamEcc,
                                               srcUpdownCounter2, srcGraphics);

  // next values of the registered outputs
  reg                next_valid;
  reg  [7:0]         next_vector;
  reg  [31:0]        next_address;
  reg  [LEVEL_W-1:0] next_level;
  reg                next_present;
  reg                next_fixed;
  reg                next_soft;
  reg                next_fault;
  reg                next_dma;
  reg                next_indexValid;
  reg  [5:0]         next_index;

  // strobes last one cycle per taken request
  // back-to-back requests give back-to-back strobes
  always @*
  begin
    next_valid = reqValid;
    // a blocked source keeps its index but raises no request
    next_dma   = reqValid && withIndex && !blocked;
  end

  // data outputs hold between requests for a late reader
  always @*
  begin
    next_vector  = mapVector;
    next_address = vectorAddress;
    if (reqValid)
    begin
      next_vector  = reqVector;
      // single-bit RAM errors at 61 land at 0x308, mfs0 tx at 0x3a8
      next_address = vectorTableBase + vecOffset(reqVector);
    end
  end

  // level: fixed for the non-maskable vector, register for peripherals
  // level registers are read only for vectors 16..63
  always @*
  begin
    next_level = vectorLevel;
    if (reqValid)
    begin
      if (isNmi)
        next_level = `IVM_NMI_LEVEL;
      else if (isPeripheral)
        // vector 21 -> register 5, vector 47 -> register 31
        next_level = sourceLevelRegister[levelSel*LEVEL_W +: LEVEL_W];
      else
        next_level = {LEVEL_W{1'h0}};
    end
  end

  // classification flags
  always @*
  begin
    next_present = levelPresent;
    next_fixed   = levelFixed;
    next_soft    = softInterrupt;
    next_fault   = faultException;
    if (reqValid)
    begin
      // exceptions 6 and 7 report no level
      next_present = isPeripheral || isNmi;
      next_fixed   = isNmi;
      next_soft    = isSoft;
      next_fault   = isFault(reqVector);
    end
  end

  // dma index reporting
  // index is meaningful only while dmaIndexValid is high
  always @*
  begin
    next_indexValid = dmaIndexValid;
    next_index      = dmaResourceIndex;
    if (reqValid)
    begin
      next_indexValid = withIndex;
      next_index      = levelSel;
    end
  end

  // every output comes from a register below; reset clears all of them
  // strobe registers
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      mapValid   <= 1'h0;
      dmaRequest <= 1'h0;
    end
    else
    begin
      mapValid   <= next_valid;
      dmaRequest <= next_dma;
    end
  end

  // address, vector and level registers
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      mapVector     <= 8'h00;
      vectorAddress <= 32'h0000_0000;
      vectorLevel   <= {LEVEL_W{1'h0}};
    end
    else
    begin
      mapVector     <= next_vector;
      vectorAddress <= next_address;
      vectorLevel   <= next_level;
    end
  end

  // classification registers
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      levelPresent   <= 1'h0;
      levelFixed     <= 1'h0;
      softInterrupt  <= 1'h0;
      faultException <= 1'h0;
    end
    else
    begin
      levelPresent   <= next_present;
      levelFixed     <= next_fixed;
      softInterrupt  <= next_soft;
      faultException <= next_fault;
    end
  end

  // dma index registers
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      dmaIndexValid    <= 1'h0;
      dmaResourceIndex <= 6'h00;
    end
    else
    begin
      dmaIndexValid    <= next_indexValid;
      dmaResourceIndex <= next_index;
    end
  end

endmodule

// *** design/ivm_defines.vh ***
`ifndef IVM_DEFINES_VH
`define IVM_DEFINES_VH

// vector address = base + (TOP_OFFSET - 4 * vector)
`define IVM_TOP_OFFSET      32'h0000_03fc
`define IVM_TABLE_BASE_RESET 32'h000f_fc00
// exception and request vector numbers
`define IVM_VEC_IPROT       8'h06
`define IVM_VEC_DPROT       8'h07
`define IVM_VEC_DERR        8'h08
`define IVM_VEC_UNDEF       8'h0e
`define IVM_VEC_NMI         8'h0f
`define IVM_NMI_LEVEL       5'h0f
// peripheral vector range with level registers
`define IVM_VEC_PERI_FIRST  8'h10
`define IVM_VEC_PERI_LAST   8'h3f
// first vector of the software interrupt instruction range
`define IVM_VEC_SOFT_FIRST  8'h42
// vectors of note
`define IVM_VEC_MFS0_TX     8'h15
`define IVM_VEC_CAL_SUB     8'h2f
`define IVM_VEC_RAM_SBE     8'h3d
// vectors with no dma resource index
`define IVM_VEC_NORES_A0    8'h22
`define IVM_VEC_NORES_A1    8'h25
`define IVM_VEC_NORES_B0    8'h32
`define IVM_VEC_NORES_B1    8'h33
`define IVM_VEC_NORES_C0    8'h3e

`endif

// *** testbench/ivm_checker.sv ***
module ivm_checker (
  // watched mapper ports
  input wire logic        mclk, sys_rst, reqValid, srcClockCalib, srcRamEcc,
  input wire logic        mapValid, levelPresent, levelFixed, softInterrupt,
  input wire logic        faultException, dmaRequest,
  input wire logic [7:0]  reqVector,
  input wire logic [31:0] vectorTableBase, vectorAddress,
  input wire logic [4:0]  vectorLevel
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_answer_next: assert property (reqValid |=> mapValid)
    else $error("no answer");
  a_addr_sum: assert property (reqValid |=> vectorAddress ==
    $past(vectorTableBase) + 32'h3fc - {$past(reqVector), 2'h0}) else $error("bad address");
  a_soft_range: assert property (reqValid |=> softInterrupt == ($past(reqVector) > 8'h41))
    else $error("bad soft flag");
  a_fault_set: assert property (reqValid |=> faultException ==
    ($past(reqVector) inside {8'h06, 8'h07, 8'h08, 8'h0e})) else $error("bad fault flag");
  a_no_level: assert property (reqValid && reqVector inside {8'h06, 8'h07} |=> !levelPresent)
    else $error("level on protection");
  a_nmi_fixed: assert property (reqValid && reqVector == 8'h0f |=> levelFixed &&
    vectorLevel == 5'h0f) else $error("bad nmi level");
  a_calib_nodma: assert property (reqValid && srcClockCalib |=> !dmaRequest)
    else $error("calib dma");
  a_ecc_nodma: assert property (reqValid && srcRamEcc |=> !dmaRequest)
    else $error("ecc dma");
  a_nores_nodma: assert property (reqValid && reqVector == 8'h32 |=> !dmaRequest)
    else $error("dma without index");
  c_nmi: cover property (reqValid && reqVector == 8'h0f);
  c_soft: cover property (softInterrupt);
  c_dma: cover property (dmaRequest);
endmodule
bind ivm_mapper ivm_checker i_ivm_checker (
  .mclk(mclk), .sys_rst(sys_rst), .reqValid(reqValid), .srcClockCalib(srcClockCalib),
  .srcRamEcc(srcRamEcc), .mapValid(mapValid), .levelPresent(levelPresent),
  .levelFixed(levelFixed), .softInterrupt(softInterrupt), .faultException(faultException),
  .dmaRequest(dmaRequest), .reqVector(reqVector), .vectorTableBase(vectorTableBase),
  .vectorAddress(vectorAddress), .vectorLevel(vectorLevel)
);

// *** testbench/ivm_source_model.sv ***
module ivm_source_model (
  // bench stimulus
  input wire logic       mclk, fire,
  input wire logic [7:0] vec,
  input wire logic [4:0] q,
  // request to mapper
  output logic           reqValid = 1'h0,
  output logic [7:0]     reqVector = 8'h00,
  output logic           srcI2cStatus = 1'h0, srcClockCalib = 1'h0, srcRamEcc = 1'h0,
  output logic           srcUpdownCounter2 = 1'h0, srcGraphics = 1'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle lines toggle so stale values never pose as a request
  always @(posedge mclk)
  begin
    reqValid <= fire;
    reqVector <= fire ? vec : ~reqVector;
    {srcI2cStatus, srcClockCalib, srcRamEcc, srcUpdownCounter2, srcGraphics} <= fire ? q :
      ~{srcI2cStatus, srcClockCalib, srcRamEcc, srcUpdownCounter2, srcGraphics};
  end
endmodule

// *** testbench/ivm_mapper_tb.sv ***
`include "ivm_defines.vh"
module ivm_mapper_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, sys_rst = 1, fire = 0, reqValid, mapValid, levelPresent, levelFixed;
  logic srcI2cStatus, srcClockCalib, srcRamEcc, srcUpdownCounter2, srcGraphics;
  logic softInterrupt, faultException, dmaRequest, dmaIndexValid;
  logic [7:0] vec = 0, reqVector, mapVector;
  logic [4:0] q = 0, vectorLevel;
  logic [5:0] dmaResourceIndex;
  logic [31:0] vectorTableBase = `IVM_TABLE_BASE_RESET, vectorAddress;
  logic [239:0] sourceLevelRegister;
  int errCount = 0, numChecks = 0, cyc = 0;
  always #4 mclk = ~mclk;
  ivm_source_model i_ivm_source_model (.*);
  ivm_mapper i_ivm_mapper (.*);
  task automatic chk(string n, logic [31:0] s, e);
    numChecks++;
    if (s !== e)
    begin
      errCount++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic go(logic [7:0] v, logic [4:0] f);
    @(posedge mclk);
    fire <= 1;
    vec <= v;
    q <= f;
    @(posedge mclk);
    fire <= 0;
    @(posedge mclk);
    #1;
    chk("valid", mapValid, 1);
    chk("vec", mapVector, v);
    chk("addr", vectorAddress, vectorTableBase + 32'h3fc - 4 * v);
  endtask
  task automatic t_exc;
    logic [7:0] fv[5] = '{6, 7, 8, 14, 15};
    foreach (fv[i])
    begin
      go(fv[i], 0);
      chk("fault", faultException, fv[i] != 15);
      chk("fixed", {levelPresent, levelFixed, vectorLevel}, fv[i] == 15 ? 7'h6f : 0);
    end
  endtask
  task automatic t_nodma;
    logic [7:0] nv[6] = '{20, 47, 61, 42, 45, 50};
    foreach (nv[i])
    begin
      go(nv[i], i < 5 ? 5'h10 >> i : 5'h00);
      chk("dma", {dmaIndexValid, dmaRequest}, {nv[i] != 50, 1'h0});
    end
  endtask
  task automatic t_soft;
    logic [7:0] sv[3] = '{65, 66, 255};
    foreach (sv[i])
    begin
      go(sv[i], 0);
      chk("soft", softInterrupt, sv[i] > 65);
    end
  endtask
  task automatic t_peri;
    logic [7:0] pv[5] = '{16, 21, 47, 61, 63};
    @(posedge mclk);
    vectorTableBase <= 32'h0012_3400;
    foreach (pv[i])
    begin
      go(pv[i], 0);
      chk("level", vectorLevel, 5'(pv[i] - 16) ^ 5'h0a);
      chk("req", dmaRequest, pv[i] != 63);
      if (pv[i] != 63)
        chk("idx", dmaResourceIndex, pv[i] - 16);
    end
  endtask
  task automatic testDone;
    $display("checks %0d errors %0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge mclk)
    if (++cyc == 1000)
    begin
      errCount++;
      testDone;
    end
  initial
  begin
    for (int k = 0; k < 48; k++)
      sourceLevelRegister[k*5+:5] <= 5'(k) ^ 5'h0a;
    repeat (12) @(posedge mclk);
    sys_rst <= 0;
    t_exc;
    t_nodma;
    t_soft;
    t_peri;
    testDone;
  end
endmodule
